// file: dtp_timing.sv
// Upper DRAM timing register and the command spacing it enforces
// ==========================================================
module dtp_timing
  import dtp_pkg::*;
#(
  parameter int NRANK = 8,
  parameter int RANK_W = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  // Operating point, from same-clock configuration logic
  input wire logic [1:0] ddr_freq,
  // Commands issued by the scheduler
  input wire logic cmd_issue,
  input wire dtp_cmd_t cmd_kind,
  input wire logic [RANK_W-1:0] cmd_rank,
  // Issue permissions for the next command clock
  output logic [NRANK-1:0] act_ok_q,
  output logic [NRANK-1:0] rd_ok_q,
  output logic [NRANK-1:0] wr_ok_q,
  output logic ref_ok_q,
  output logic cfg_bad_q
);

  // ==========================================================
  // Timing register
  logic [31:0] dram_timing_params_q;
  wire reg_hit = (cfg_addr == DTP_REG_OFFSET);
  wire reg_we = cfg_wr && reg_hit;
  wire [31:0] reg_rd_val = reg_hit ? dram_timing_params_q : 32'h0000_0000;

  // Masked write keeps reserved and out-of-scope bits at zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dram_timing_params_q <= DTP_RESET;
    end else if (reg_we) begin
      dram_timing_params_q <= cfg_wdata & DTP_WR_MASK;
    end
  end

  // Read answer one clock after the strobe; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_rdata_q <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rdata_q <= cfg_rd ? reg_rd_val : 32'h0000_0000;
      cfg_rvalid_q <= cfg_rd;
    end
  end

  // ==========================================================
  // Field decode to command clocks
  dtp_cnt_if tif ();
  assign tif.freq = ddr_freq;
  genvar f;
  generate
    for (f = 0; f < NFIELD; f++) begin : g_code
      assign tif.code[f] = dram_timing_params_q[FIELD_LSB[f] +: 2];
    end
  endgenerate
  dtp_decode u_decode (
    .tif (tif.dec)
  );

  // ==========================================================
  // Spacing loads; a counter loaded with L admits the next command L+1 clocks later.
  // All counts are command clocks, so counters tick on every sys_clk edge.
  wire slot_add = dram_timing_params_q[SLOT_ADD_BIT];
  wire dtp_cnt_t ld_wrrd = 6'(BURST_CLKS + tif.cnt[F_WRRD] - CNT_ONE - CNT_ONE);
  wire dtp_cnt_t ld_wtr = 6'(BURST_CLKS + tif.cnt[F_WTR] - CNT_ONE);
  wire dtp_cnt_t ld_rdwr = 6'(BURST_CLKS + tif.cnt[F_RDWR] - CNT_ONE - CNT_ONE);
  wire dtp_cnt_t ld_rkrd = 6'(BURST_CLKS + tif.cnt[F_RKRD] - CNT_ONE - CNT_ONE);
  wire dtp_cnt_t ld_slot = 6'(BURST_CLKS + tif.cnt[F_RKRD] - CNT_ONE);
  wire dtp_cnt_t ld_col = 6'(BURST_CLKS - CNT_ONE);
  wire dtp_cnt_t ld_rfc = 6'(tif.cnt[F_RFC] - CNT_ONE);
  wire dtp_cnt_t ld_rrd = 6'(tif.cnt[F_RRD] - CNT_ONE);
  wire dtp_cnt_t ld_rc = 6'(tif.cnt[F_RC] - CNT_ONE);
  wire dtp_cnt_t ld_dal = 6'(BURST_CLKS + tif.cnt[F_DAL] - CNT_ONE);
  wire dtp_cnt_t ld_rcd = 6'(tif.cnt[F_RCD] - CNT_ONE);

  // Command classes seen this clock
  wire is_act = cmd_issue && (cmd_kind == CMD_ACT);
  wire is_rd = cmd_issue && (cmd_kind == CMD_RD);
  wire is_wr = cmd_issue && ((cmd_kind == CMD_WR) || (cmd_kind == CMD_WRA));
  wire is_wra = cmd_issue && (cmd_kind == CMD_WRA);
  wire is_ref = cmd_issue && (cmd_kind == CMD_REF);
  wire [RANK_W-2:0] cmd_slot = cmd_rank[RANK_W-1:1];
  wire slot_last = (cmd_slot == {(RANK_W-1){1'b1}});

  // Count down, or take the longer of the running and new spacing so no limit is cut short
  function automatic dtp_cnt_t step(input dtp_cnt_t cur, input logic load, input dtp_cnt_t val);
    dtp_cnt_t dec;
    dec = (cur == CNT_ZERO) ? CNT_ZERO : 6'(cur - CNT_ONE);
    step = (load && (val > dec)) ? val : dec;
  endfunction

  // ==========================================================
  // Shared spacing counters
  dtp_cnt_t wrrd_q, rdwr_q, rkrd_q, slot_q, col_q, rfc_q, rrd_q;
  logic [RANK_W-1:0] last_rd_rank_q, last_act_rank_q;
  wire dtp_cnt_t wrrd_d = step(wrrd_q, is_wr, (ld_wtr > ld_wrrd) ? ld_wtr : ld_wrrd);
  wire dtp_cnt_t rdwr_d = step(rdwr_q, is_rd, ld_rdwr);
  wire dtp_cnt_t rkrd_d = step(rkrd_q, is_rd, ld_rkrd);
  wire dtp_cnt_t slot_d = step(slot_q, is_rd && slot_add && slot_last, ld_slot);
  wire dtp_cnt_t col_d = step(col_q, is_rd || is_wr, ld_col);
  wire dtp_cnt_t rfc_d = step(rfc_q, is_ref, ld_rfc);
  wire dtp_cnt_t rrd_d = step(rrd_q, is_act, ld_rrd);
  wire [RANK_W-1:0] last_rd_rank_d = is_rd ? cmd_rank : last_rd_rank_q;
  wire [RANK_W-1:0] last_act_rank_d = is_act ? cmd_rank : last_act_rank_q;

  // Shared counters update; every edge is one command clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrrd_q <= CNT_ZERO;
      rdwr_q <= CNT_ZERO;
      rkrd_q <= CNT_ZERO;
      slot_q <= CNT_ZERO;
      col_q <= CNT_ZERO;
      rfc_q <= CNT_ZERO;
      rrd_q <= CNT_ZERO;
      last_rd_rank_q <= '0;
      last_act_rank_q <= '0;
    end else begin
      wrrd_q <= wrrd_d;
      rdwr_q <= rdwr_d;
      rkrd_q <= rkrd_d;
      slot_q <= slot_d;
      col_q <= col_d;
      rfc_q <= rfc_d;
      rrd_q <= rrd_d;
      last_rd_rank_q <= last_rd_rank_d;
      last_act_rank_q <= last_act_rank_d;
    end
  end

  // ==========================================================
  // Per-rank counters and permissions, computed from next state so they carry no lag
  logic [NRANK-1:0] bank_idle_d;
  logic [NRANK-1:0] rd_ok_d, wr_ok_d, act_ok_d;
  genvar r;
  generate
    for (r = 0; r < NRANK; r++) begin : g_rank
      dtp_cnt_t rc_q, dal_q, rcd_q;
      wire hit = (cmd_rank == RANK_W'(r));
      wire dtp_cnt_t rc_d = step(rc_q, is_act && hit, ld_rc);
      wire dtp_cnt_t dal_d = step(dal_q, is_wra && hit, ld_dal);
      wire dtp_cnt_t rcd_d = step(rcd_q, is_act && hit, ld_rcd);
      wire same_rd = (last_rd_rank_d == RANK_W'(r));
      wire same_act = (last_act_rank_d == RANK_W'(r));
      wire to_slot0 = (r / 2 == 0);
      // Read admits: write turnaround, column gap, activate delay, refresh, rank switch, slot switch
      assign rd_ok_d[r] = (wrrd_d == CNT_ZERO) && (col_d == CNT_ZERO) && (rcd_d == CNT_ZERO)
                          && (rfc_d == CNT_ZERO) && (same_rd || (rkrd_d == CNT_ZERO))
                          && !(to_slot0 && (slot_d != CNT_ZERO));
      assign wr_ok_d[r] = (rdwr_d == CNT_ZERO) && (col_d == CNT_ZERO) && (rcd_d == CNT_ZERO)
                          && (rfc_d == CNT_ZERO);
      assign act_ok_d[r] = (rfc_d == CNT_ZERO) && (rc_d == CNT_ZERO) && (dal_d == CNT_ZERO)
                           && (!same_act || (rrd_d == CNT_ZERO));
      assign bank_idle_d[r] = (rc_d == CNT_ZERO) && (dal_d == CNT_ZERO);

      // Rank counters
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          rc_q <= CNT_ZERO;
          dal_q <= CNT_ZERO;
          rcd_q <= CNT_ZERO;
        end else begin
          rc_q <= rc_d;
          dal_q <= dal_d;
          rcd_q <= rcd_d;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Refresh permission and reserved-code flag
  wire ref_ok_d = (rfc_d == CNT_ZERO) && (&bank_idle_d);

  // A reserved code still runs at the slowest legal timing; the flag only tells software.
  // Permission vectors are registered whole here so each output has a single driver.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_ok_q <= '0;
      wr_ok_q <= '0;
      act_ok_q <= '0;
      ref_ok_q <= 1'b0;
      cfg_bad_q <= 1'b0;
    end else begin
      rd_ok_q <= rd_ok_d;
      wr_ok_q <= wr_ok_d;
      act_ok_q <= act_ok_d;
      ref_ok_q <= ref_ok_d;
      cfg_bad_q <= |tif.bad;
    end
  end

endmodule

// file: dtp_pkg.sv
// Constants, tables and types for the DRAM command-timing parameter block
package dtp_pkg;

  // ==========================================================
  // Register location and layout
  localparam logic [7:0] DTP_REG_OFFSET = 8'h78;
  localparam logic [31:0] DTP_WR_MASK = 32'h7FFC_FC00;  // Bits 31, 17:16 and 9:0 stay zero
  localparam logic [31:0] DTP_RESET = 32'h0000_0000;
  localparam int SLOT_ADD_BIT = 30;

  // ==========================================================
  // Two-bit timing fields, in table order
  localparam int NFIELD = 9;
  localparam int F_WRRD = 0;
  localparam int F_RDWR = 1;
  localparam int F_RKRD = 2;
  localparam int F_RFC = 3;
  localparam int F_RRD = 4;
  localparam int F_WTR = 5;
  localparam int F_RC = 6;
  localparam int F_DAL = 7;
  localparam int F_RCD = 8;
  localparam int FIELD_LSB [NFIELD] = '{28, 26, 24, 22, 20, 18, 14, 12, 10};

  // ==========================================================
  // Counts in command clocks, index {freq, code}; zero marks a reserved encoding
  localparam int CNT_W = 6;
  typedef logic [CNT_W-1:0] dtp_cnt_t;
  localparam dtp_cnt_t CNT_TBL [NFIELD][16] = '{
    '{6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h01, 6'h02, 6'h03, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h01, 6'h02, 6'h03, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h01, 6'h02, 6'h00, 6'h00, 6'h01, 6'h02, 6'h03, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h00, 6'h00, 6'h0A, 6'h10, 6'h00, 6'h00, 6'h0D, 6'h14, 6'h0F, 6'h15, 6'h1A, 6'h28, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h01, 6'h02, 6'h03, 6'h00, 6'h01, 6'h02, 6'h03, 6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h01, 6'h02, 6'h03, 6'h00, 6'h01, 6'h02, 6'h03, 6'h00, 6'h02, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h00, 6'h08, 6'h09, 6'h00, 6'h00, 6'h00, 6'h0A, 6'h00, 6'h00, 6'h0C, 6'h0D, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h04, 6'h05, 6'h00, 6'h00, 6'h00, 6'h06, 6'h00, 6'h00, 6'h06, 6'h07, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
    '{6'h00, 6'h02, 6'h03, 6'h04, 6'h00, 6'h03, 6'h05, 6'h06, 6'h00, 6'h03, 6'h04, 6'h05, 6'h00, 6'h00, 6'h00, 6'h00}
  };
  // Longest legal count per field, used when a reserved code is programmed
  localparam dtp_cnt_t CNT_SAFE [NFIELD] = '{6'h03, 6'h03, 6'h03, 6'h28, 6'h04, 6'h03, 6'h0D, 6'h07, 6'h06};

  // ==========================================================
  // Data burst length in command clocks and reset values
  localparam dtp_cnt_t BURST_CLKS = 6'h02;
  localparam dtp_cnt_t CNT_ZERO = 6'h00;
  localparam dtp_cnt_t CNT_ONE = 6'h01;

  // ==========================================================
  // Operating points and scheduler commands
  typedef enum logic [1:0] {
    FREQ_266 = 2'b00,
    FREQ_333 = 2'b01,
    FREQ_400 = 2'b10
  } dtp_freq_t;

  typedef enum logic [2:0] {
    CMD_ACT = 3'b000,
    CMD_RD = 3'b001,
    CMD_WR = 3'b010,
    CMD_WRA = 3'b011,
    CMD_REF = 3'b100,
    CMD_NOP = 3'b111
  } dtp_cmd_t;

endpackage

// file: dtp_cnt_if.sv
// Field codes out to the count decoder and command-clock counts back
interface dtp_cnt_if;
  import dtp_pkg::*;
  logic [1:0] freq;
  logic [1:0] code [NFIELD];
  dtp_cnt_t cnt [NFIELD];
  logic [NFIELD-1:0] bad;
  modport dec (input freq, input code, output cnt, output bad);
  modport ctl (output freq, output code, input cnt, input bad);
endinterface

// file: dtp_decode.sv
// Turns each timing field code into a count of command clocks
module dtp_decode
  import dtp_pkg::*;
(
  // Codes in, counts out
  dtp_cnt_if.dec tif
);

  // ==========================================================
  // Table lookup, one per field
  genvar i;
  generate
    for (i = 0; i < NFIELD; i++) begin : g_fld
      wire [3:0] idx = {tif.freq, tif.code[i]};
      wire dtp_cnt_t raw = CNT_TBL[i][idx];
      // Reserved codes fall back to the slowest legal timing, never to zero spacing
      assign tif.bad[i] = (raw == CNT_ZERO);
      assign tif.cnt[i] = (raw == CNT_ZERO) ? CNT_SAFE[i] : raw;
    end
  endgenerate

endmodule

// file: dtp_chk.sv
// Port-level assertions for the DRAM command-timing block
module dtp_chk
  import dtp_pkg::*;
#(
  parameter int NRANK = 8,
  parameter int RANK_W = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration access
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q,
  // Scheduler commands
  input wire logic cmd_issue,
  input wire dtp_cmd_t cmd_kind,
  input wire logic [RANK_W-1:0] cmd_rank,
  // Issue permissions
  input wire logic [NRANK-1:0] act_ok_q,
  input wire logic [NRANK-1:0] rd_ok_q,
  input wire logic [NRANK-1:0] wr_ok_q,
  input wire logic ref_ok_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Everything here is one command clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  rvalid_pulse_a: assert property (cfg_rd ##1 !cfg_rd |-> cfg_rvalid_q ##1 !cfg_rvalid_q)
    else $error("read valid is not a single pulse");
  unmapped_zero_a: assert property (cfg_rd && cfg_addr != DTP_REG_OFFSET |=> cfg_rdata_q == 32'h0000_0000)
    else $error("unmapped read returned data");
  rsvd_zero_a: assert property (cfg_rvalid_q |-> (cfg_rdata_q & ~DTP_WR_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  wr_rd_turn_a: assert property (cmd_issue && cmd_kind == CMD_WR |=> rd_ok_q == '0)
    else $error("read allowed right after write");
  rd_wr_turn_a: assert property (cmd_issue && cmd_kind == CMD_RD |=> wr_ok_q == '0)
    else $error("write allowed right after read");
  ref_block_a: assert property (cmd_issue && cmd_kind == CMD_REF |=> (act_ok_q == '0 && !ref_ok_q)[*8])
    else $error("refresh cycle time not held");
  act_rank_a: assert property (cmd_issue && cmd_kind == CMD_ACT |=> !act_ok_q[$past(cmd_rank)])
    else $error("activate allowed right after activate");
  act_col_a: assert property (cmd_issue && cmd_kind == CMD_ACT |=> !rd_ok_q[$past(cmd_rank)])
    else $error("column access allowed right after activate");
  // Same-rank reads never need a bubble, so the rank reopens after one burst
  rd_b2b_a: assert property (cmd_issue && cmd_kind == CMD_RD ##1 !cmd_issue |=> rd_ok_q[$past(cmd_rank, 2)])
    else $error("same rank read not reopened after one burst");
endmodule

// file: dtp_mem_model.sv
// Memory-side model that measures the spacing of commands it receives
module dtp_mem_model
  import dtp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Commands arriving at the modules
  input wire logic cmd_issue,
  input wire dtp_cmd_t cmd_kind,
  // Clocks between the last two commands
  output logic [5:0] gap_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] since_q;
  // One count per command clock; the count saturates at 63, so the gap reported after a longer idle wraps to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      since_q <= 6'h3F;
      gap_q <= 6'h00;
    end else if (cmd_issue && cmd_kind != CMD_NOP) begin
      gap_q <= since_q + 6'h01;
      since_q <= 6'h00;
    end else if (since_q != 6'h3F) begin
      since_q <= since_q + 6'h01;
    end
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the DRAM command-timing block
module tb_top
  import dtp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, cfg_wr, cfg_rd, cmd_issue, cfg_rvalid_q, ref_ok_q, cfg_bad_q;
  logic [7:0] cfg_addr, act_ok_q, rd_ok_q, wr_ok_q;
  logic [31:0] cfg_wdata, cfg_rdata_q;
  logic [1:0] ddr_freq;
  logic [2:0] cmd_rank;
  logic [5:0] gap;
  dtp_cmd_t cmd_kind;
  int err_count = 0;
  int check_count = 0;
  dtp_timing #(.NRANK(8), .RANK_W(3)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
    .ddr_freq(ddr_freq), .cmd_issue(cmd_issue), .cmd_kind(cmd_kind), .cmd_rank(cmd_rank), .act_ok_q(act_ok_q),
    .rd_ok_q(rd_ok_q), .wr_ok_q(wr_ok_q), .ref_ok_q(ref_ok_q), .cfg_bad_q(cfg_bad_q));
  dtp_mem_model mem (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_issue(cmd_issue), .cmd_kind(cmd_kind), .gap_q(gap));
  // ==========================================================
  // Clock and shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs change one step after the edge so the sampling edge never races them
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick();
    cfg_wr = 1'b0;
  endtask
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    cfg_rd = 1'b1;
    cfg_addr = a;
    tick();
    cfg_rd = 1'b0;
    check({31'h0, cfg_rvalid_q}, 32'h1);
    check(cfg_rdata_q, exp);
    // One idle edge so a following read never re-raises the strobe in this time step
    tick();
  endtask
  function automatic logic ok(input dtp_cmd_t k, input logic [2:0] r);
    case (k)
      CMD_ACT: ok = act_ok_q[r];
      CMD_RD: ok = rd_ok_q[r];
      CMD_REF: ok = ref_ok_q;
      default: ok = wr_ok_q[r];
    endcase
  endfunction
  // Scheduler side: never issues against a closed permission; the strobe stays up
  // between back-to-back commands and the caller drops it after the last one
  task automatic issue(input dtp_cmd_t k, input logic [2:0] r);
    int n;
    n = 0;
    while (ok(k, r) !== 1'b1) begin
      cmd_issue = 1'b0;
      cmd_kind = CMD_NOP;
      n++;
      if (n > 80) begin
        err_count++;
        results();
      end
      tick();
    end
    cmd_issue = 1'b1;
    cmd_kind = k;
    cmd_rank = r;
    tick();
  endtask
  // Idle past the longest count of any field (40), then time one command pair
  task automatic gap_chk(input dtp_cmd_t k1, input logic [2:0] r1, input dtp_cmd_t k2, input logic [2:0] r2,
                         input logic [5:0] exp);
    repeat (45) tick();
    issue(k1, r1);
    issue(k2, r2);
    cmd_issue = 1'b0;
    cmd_kind = CMD_NOP;
    check({26'h0, gap}, {26'h0, exp});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cmd_issue = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0000_0000;
    ddr_freq = FREQ_400;
    cmd_kind = CMD_NOP;
    cmd_rank = 3'h0;
    repeat (5) tick();
    rst_n = 1'b1;
    tick();
    check({31'h0, cfg_bad_q}, 32'h1);
    cfg_read(DTP_REG_OFFSET, DTP_RESET);
    cfg_write(DTP_REG_OFFSET, 32'hFFFF_FFFF);
    cfg_read(DTP_REG_OFFSET, DTP_WR_MASK);
    cfg_write(8'h7C, 32'h0000_0000);
    cfg_read(8'h7C, 32'h0000_0000);
    cfg_read(DTP_REG_OFFSET, DTP_WR_MASK);
    $display("test registers done");
    // Legal 400 MHz set with the slot turnaround add on
    cfg_write(DTP_REG_OFFSET, 32'h7930_9C00);
    tick();
    check({31'h0, cfg_bad_q}, 32'h0);
    gap_chk(CMD_WR, 3'h0, CMD_RD, 3'h1, 6'h04);
    gap_chk(CMD_WR, 3'h2, CMD_RD, 3'h2, 6'h04);
    gap_chk(CMD_RD, 3'h0, CMD_WR, 3'h3, 6'h03);
    gap_chk(CMD_RD, 3'h1, CMD_WR, 3'h1, 6'h03);
    gap_chk(CMD_RD, 3'h0, CMD_RD, 3'h2, 6'h02);
    gap_chk(CMD_RD, 3'h6, CMD_RD, 3'h0, 6'h03);
    gap_chk(CMD_ACT, 3'h1, CMD_ACT, 3'h2, 6'h01);
    gap_chk(CMD_ACT, 3'h1, CMD_ACT, 3'h1, 6'h0D);
    gap_chk(CMD_ACT, 3'h3, CMD_RD, 3'h3, 6'h05);
    gap_chk(CMD_WRA, 3'h4, CMD_ACT, 3'h4, 6'h09);
    gap_chk(CMD_REF, 3'h0, CMD_ACT, 3'h5, 6'h0F);
    $display("test 400 MHz spacing done");
    // Same write-to-read, refresh and activate-to-activate codes become reserved once the clock drops to 266 MHz
    ddr_freq = FREQ_266;
    tick();
    check({31'h0, cfg_bad_q}, 32'h1);
    cfg_write(DTP_REG_OFFSET, 32'h1588_4400);
    tick();
    check({31'h0, cfg_bad_q}, 32'h0);
    gap_chk(CMD_WR, 3'h0, CMD_RD, 3'h1, 6'h05);
    gap_chk(CMD_RD, 3'h0, CMD_WR, 3'h1, 6'h02);
    gap_chk(CMD_REF, 3'h0, CMD_ACT, 3'h2, 6'h0A);
    gap_chk(CMD_ACT, 3'h2, CMD_RD, 3'h2, 6'h02);
    gap_chk(CMD_ACT, 3'h2, CMD_ACT, 3'h2, 6'h08);
    $display("test 266 MHz spacing done");
    results();
  end
endmodule
bind dtp_timing dtp_chk #(.NRANK(NRANK), .RANK_W(RANK_W)) chk (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .cmd_issue(cmd_issue),
  .cmd_kind(cmd_kind), .cmd_rank(cmd_rank), .act_ok_q(act_ok_q), .rd_ok_q(rd_ok_q), .wr_ok_q(wr_ok_q),
  .ref_ok_q(ref_ok_q));
